// [pkg/cic_defs.vh]
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH
// Word indices of the two control registers; the byte address is four times the index
`define CIC_IDX_CTRL 8'h0B
`define CIC_IDX_PFLAG 8'h0C
// Register byte offsets, every register on its own aligned word
`define CIC_OFS_CTRL (`CIC_IDX_CTRL << 2)
`define CIC_OFS_PFLAG (`CIC_IDX_PFLAG << 2)
`define CIC_OFS_PEN 8'h10
`define CIC_OFS_IOC 8'h14
`define CIC_OFS_PORT 8'h18
`define CIC_OFS_TIMER 8'h1C
`define CIC_OFS_ISTAT 8'h20
`define CIC_OFS_IMASK 8'h24
// Interrupt control field positions
`define CIC_GIE_BIT 7
`define CIC_PERIPHERAL_GROUP_ENABLE_BIT 6
`define CIC_TOE_BIT 5
`define CIC_EXE_BIT 4
`define CIC_PCE_BIT 3
`define CIC_TOF_BIT 2
`define CIC_EXF_BIT 1
`define CIC_PCF_BIT 0
// Reset values and timer maximum
`define CIC_CTRL_RST 8'h00
`define CIC_PFLAG_RST 8'h00
`define CIC_TIMER_MAX 8'hFF
// Bus responses
`define CIC_RESP_OKAY 2'h0
`define CIC_RESP_SLVERR 2'h2
`endif

// [rtl/cic_change_detect.v]
`timescale 1ns/100ps
// Port change detector: compares pins with the value latched at last port access
module cic_change_detect #(
  parameter PINS = 6
) (
  // Clock and enable
  input wire mclk,
  input wire ce,
  // Port side
  input wire [PINS-1:0] portPins,
  input wire [PINS-1:0] detectEnables,
  input wire portAccess,
  // Result
  output wire mismatch
);
  reg [PINS-1:0] lastRead_reg;
  // Latch is deliberately not reset, so its value survives a reset; the mismatch stays masked until the enables are written again
  always @(posedge mclk) begin
    if (ce && portAccess) begin
      lastRead_reg <= portPins;
    end
  end
  // Mismatch of any enabled pin
  assign mismatch = |((portPins ^ lastRead_reg) & detectEnables);
endmodule

// [rtl/cic_timer.v]
`timescale 1ns/100ps
// Free running eight bit timer with overflow pulse
module cic_timer #(
  parameter W = 8
) (
  // Clock and enable
  input wire mclk,
  input wire ce,
  // Software load and count tick
  input wire load,
  input wire [W-1:0] loadValue,
  input wire tick,
  // Status
  output reg [W-1:0] count,
  output reg overflow
);
  // No reset: the count is left as it was
  always @(posedge mclk) begin
    if (ce) begin
      overflow <= 1'b0;
      if (load) begin
        count <= loadValue;
      end else if (tick) begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
        overflow <= &count;
      end
    end
  end
endmodule

// [rtl/cic_core_irq.v]
`timescale 1ns/100ps
`include "cic_defs.vh"
module cic_core_irq #(
  parameter PINS = 6,
  parameter PFLAGS = 8
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst,
  input wire ce,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Event sources and core sleep state
  input wire timerTick,
  input wire externalIrqPin,
  input wire [PINS-1:0] portPins,
  input wire [PFLAGS-1:0] periphEvents,
  input wire coreSleeping,
  // Core side
  output reg irqRequest,
  output reg wakeRequest,
  output reg irqOut
);
  // Write state machine, one-hot
  localparam WS_IDLE = 3'b001;
  localparam WS_DATA = 3'b010;
  localparam WS_RESP = 3'b100;

  reg [2:0] wState_reg;
  reg [7:0] wAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg addrHeld_reg;
  reg dataHeld_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg [PFLAGS-1:0] pflag_reg;
  reg [PFLAGS-1:0] pflag_next;
  reg [PFLAGS-1:0] pen_reg;
  reg [PINS-1:0] ioc_reg;
  reg [7:0] istat_reg;
  reg [7:0] istat_next;
  reg [7:0] imask_reg;
  reg extPinPrev_reg;
  wire [7:0] timerCount;
  wire timerOverflow;
  wire portMismatch;
  wire wrFire;
  wire extEdge;
  wire portRead;
  wire portWrite;
  wire [7:0] events;
  wire coreHit;
  wire periphHit;

  // Register selection shared by read and write paths
  function isReg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      isReg = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  assign wrFire = (wState_reg == WS_DATA) && ce;
  assign extEdge = externalIrqPin & ~extPinPrev_reg;
  assign portRead = ce && s_axi_arvalid && s_axi_arready && isReg(s_axi_araddr, `CIC_OFS_PORT);
  assign portWrite = wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_PORT);

  // Port access refreshes the compare latch
  cic_change_detect #(
    .PINS(PINS)
  ) uChange (
    .mclk(mclk),
    .ce(ce),
    .portPins(portPins),
    .detectEnables(ioc_reg),
    .portAccess(portRead | portWrite),
    .mismatch(portMismatch)
  );

  cic_timer #(
    .W(8)
  ) uTimer (
    .mclk(mclk),
    .ce(ce),
    .load(wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_TIMER)),
    .loadValue(wData_reg[7:0]),
    .tick(timerTick),
    .count(timerCount),
    .overflow(timerOverflow)
  );

  // Event vector in control flag layout; the OR of the peripheral events takes bit 3, bits above are zero
  assign events = {4'h0, |periphEvents, timerOverflow, extEdge, portMismatch};

  // Next control value: software write, then hardware set wins
  always @* begin
    ctrl_next = ctrl_reg;
    if (wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_CTRL)) begin
      ctrl_next = wData_reg[7:0];
    end
    if (timerOverflow) begin
      ctrl_next[`CIC_TOF_BIT] = 1'b1;
    end
    if (extEdge) begin
      ctrl_next[`CIC_EXF_BIT] = 1'b1;
    end
    if (portMismatch) begin
      ctrl_next[`CIC_PCF_BIT] = 1'b1;
    end
  end

  // Peripheral flags: write stores, event sets
  always @* begin
    pflag_next = pflag_reg;
    if (wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_PFLAG)) begin
      pflag_next = wData_reg[PFLAGS-1:0];
    end
    pflag_next = pflag_next | periphEvents;
  end

  // Sticky status, write one to clear, set beats clear
  always @* begin
    istat_next = istat_reg;
    if (wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_ISTAT)) begin
      istat_next = istat_reg & ~wData_reg[7:0];
    end
    istat_next = istat_next | events;
  end

  // Request terms
  assign coreHit = |(ctrl_reg[`CIC_TOE_BIT:`CIC_PCE_BIT] & ctrl_reg[`CIC_TOF_BIT:`CIC_PCF_BIT]);
  assign periphHit = ctrl_reg[`CIC_PERIPHERAL_GROUP_ENABLE_BIT] && |(pflag_reg & pen_reg);

  // Register state
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CIC_CTRL_RST;
      pflag_reg <= `CIC_PFLAG_RST;
      pen_reg <= {PFLAGS{1'b0}};
      ioc_reg <= {PINS{1'b0}};
      istat_reg <= 8'h00;
      imask_reg <= 8'h00;
      extPinPrev_reg <= 1'b0;
      irqRequest <= 1'b0;
      wakeRequest <= 1'b0;
      irqOut <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      pflag_reg <= pflag_next;
      istat_reg <= istat_next;
      extPinPrev_reg <= externalIrqPin;
      if (wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_PEN)) begin
        pen_reg <= wData_reg[PFLAGS-1:0];
      end
      if (wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_IOC)) begin
        ioc_reg <= wData_reg[PINS-1:0];
      end
      if (wrFire && wStrb_reg[0] && isReg(wAddr_reg, `CIC_OFS_IMASK)) begin
        imask_reg <= wData_reg[7:0];
      end
      // Gating by global enable; group enable gates only the peripheral term
      irqRequest <= ctrl_reg[`CIC_GIE_BIT] && (coreHit || periphHit);
      // Wake ignores global enable so sleep ends even with interrupts off
      wakeRequest <= coreSleeping && ctrl_reg[`CIC_PCE_BIT] && ctrl_reg[`CIC_PCF_BIT];
      irqOut <= |(istat_reg & imask_reg);
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wState_reg <= WS_IDLE;
      addrHeld_reg <= 1'b0;
      dataHeld_reg <= 1'b0;
      wAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIC_RESP_OKAY;
    end else if (ce) begin
      case (wState_reg)
        WS_IDLE: begin
          s_axi_awready <= ~addrHeld_reg & ~s_axi_awready;
          s_axi_wready <= ~dataHeld_reg & ~s_axi_wready;
          if (s_axi_awvalid && s_axi_awready) begin
            wAddr_reg <= s_axi_awaddr;
            addrHeld_reg <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            dataHeld_reg <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if ((addrHeld_reg || (s_axi_awvalid && s_axi_awready)) &&
              (dataHeld_reg || (s_axi_wvalid && s_axi_wready))) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            wState_reg <= WS_DATA;
          end
        end
        WS_DATA: begin
          s_axi_bresp <= (isReg(wAddr_reg, `CIC_OFS_CTRL) || isReg(wAddr_reg, `CIC_OFS_PFLAG) ||
                          isReg(wAddr_reg, `CIC_OFS_PEN) || isReg(wAddr_reg, `CIC_OFS_IOC) ||
                          isReg(wAddr_reg, `CIC_OFS_PORT) || isReg(wAddr_reg, `CIC_OFS_TIMER) ||
                          isReg(wAddr_reg, `CIC_OFS_ISTAT) || isReg(wAddr_reg, `CIC_OFS_IMASK))
                         ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
          s_axi_bvalid <= 1'b1;
          addrHeld_reg <= 1'b0;
          dataHeld_reg <= 1'b0;
          wState_reg <= WS_RESP;
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wState_reg <= WS_IDLE;
          end
        end
        default: begin
          wState_reg <= WS_IDLE;
        end
      endcase
    end
  end

  // Read channel: one outstanding read, data one cycle after address
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CIC_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CIC_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (isReg(s_axi_araddr, `CIC_OFS_CTRL)) begin
          s_axi_rdata[7:0] <= ctrl_reg;
        end else if (isReg(s_axi_araddr, `CIC_OFS_PFLAG)) begin
          s_axi_rdata[PFLAGS-1:0] <= pflag_reg;
        end else if (isReg(s_axi_araddr, `CIC_OFS_PEN)) begin
          s_axi_rdata[PFLAGS-1:0] <= pen_reg;
        end else if (isReg(s_axi_araddr, `CIC_OFS_IOC)) begin
          s_axi_rdata[PINS-1:0] <= ioc_reg;
        end else if (isReg(s_axi_araddr, `CIC_OFS_PORT)) begin
          s_axi_rdata[PINS-1:0] <= portPins;
        end else if (isReg(s_axi_araddr, `CIC_OFS_TIMER)) begin
          s_axi_rdata[7:0] <= timerCount;
        end else if (isReg(s_axi_araddr, `CIC_OFS_ISTAT)) begin
          s_axi_rdata[7:0] <= istat_reg;
        end else if (isReg(s_axi_araddr, `CIC_OFS_IMASK)) begin
          s_axi_rdata[7:0] <= imask_reg;
        end else begin
          s_axi_rresp <= `CIC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// [verification/cic_core_irq_properties.sv]
`timescale 1ns/100ps
`include "cic_defs.vh"
// Bus handshake and core-side output checks seen from the top ports
module cic_core_irq_props (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  // Core side
  input wire coreSleeping,
  input wire irqRequest,
  input wire wakeRequest,
  input wire irqOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Bus timing as promised in the hand-over
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  a_rresp_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  // Registers are at most eight bits wide; errors return no data
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `CIC_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
  // Wake only for a sleeping core; irqRequest and irqOut quiet in reset
  a_wake_sleep: assert property (wakeRequest |-> $past(coreSleeping))
    else $error("wake without sleep");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> !irqRequest && !irqOut)
    else $error("request during reset");
endmodule

bind cic_core_irq cic_core_irq_props u_props (.mclk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .coreSleeping, .irqRequest,
  .wakeRequest, .irqOut);

// [verification/cic_src_model.sv]
`timescale 1ns/100ps
// Event sources and core sleep state; all changes land just after an edge
module cic_src_model (
  // Clock
  input wire mclk,
  // Events and core state
  output logic timerTick = 1'b0,
  output logic externalIrqPin = 1'b0,
  output logic [5:0] portPins = 6'h00,
  output logic [7:0] periphEvents = 8'h00,
  output logic coreSleeping = 1'b0
);
  // Tick for n edges; the external pin is held two edges so it cannot slip by
  task automatic tick(input int n);
    @(posedge mclk);
    timerTick <= 1'b1;
    repeat (n) @(posedge mclk);
    timerTick <= 1'b0;
  endtask
  task automatic ext_edge;
    @(posedge mclk);
    externalIrqPin <= 1'b1;
    repeat (2) @(posedge mclk);
    externalIrqPin <= 1'b0;
  endtask
  // Levels that stay until changed again
  task automatic pins(input logic [5:0] p, input logic s, input logic [7:0] e);
    @(posedge mclk);
    portPins <= p;
    coreSleeping <= s;
    periphEvents <= e;
  endtask
endmodule

// [verification/test_core_interrupt_control.sv]
`timescale 1ns/100ps
`include "cic_defs.vh"
// Self-checking bench for the interrupt control block
module test_core_interrupt_control;
  logic mclk, rst, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic timerTick, externalIrqPin, coreSleeping, irqRequest, wakeRequest, irqOut;
  logic [5:0] portPins;
  logic [7:0] periphEvents;
  int failCount = 0, checkCount = 0;
  cic_core_irq u_dut (.mclk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timerTick, .externalIrqPin, .portPins, .periphEvents,
    .coreSleeping, .irqRequest, .wakeRequest, .irqOut);
  cic_src_model u_src (.mclk, .timerTick, .externalIrqPin, .portPins, .periphEvents,
    .coreSleeping);
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checkCount++;
    if (s !== e) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus master; the leading edge keeps back-to-back calls from double-driving
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(n, rdat, e);
  endtask
  task automatic rctl(input logic [31:0] e);
    rchk("ctrl", `CIC_OFS_CTRL, e);
  endtask
  task automatic wctl(input logic [31:0] d);
    wr(`CIC_OFS_CTRL, d);
  endtask
  // Core-side outputs are registered, so let four edges pass first
  task automatic lvl(input string n, input logic e);
    repeat (4) @(posedge mclk);
    check(n, {31'h0, n == "irq" ? irqRequest : n == "out" ? irqOut : wakeRequest}, {31'h0, e});
  endtask
  task automatic t_regs;
    rctl(32'h0);
    rchk("pflag", `CIC_OFS_PFLAG, 32'h0);
    wctl(32'hFF);
    rctl(32'hFF);
    wctl(32'h00);
    check("bresp", {30'h0, resp}, {30'h0, `CIC_RESP_OKAY});
    wr(8'hFC, 32'hFF);
    check("bresp", {30'h0, resp}, {30'h0, `CIC_RESP_SLVERR});
    rctl(32'h0);
    rd(8'hFC);
    check("rresp", {30'h0, resp}, {30'h0, `CIC_RESP_SLVERR});
    $display("done: regs");
  endtask
  task automatic t_timer;
    wr(`CIC_OFS_TIMER, 32'hFE);
    u_src.tick(2);
    rctl(32'h04);
    wctl(32'h24);
    lvl("irq", 1'b0);
    wctl(32'hA4);
    lvl("irq", 1'b1);
    wctl(32'h84);
    lvl("irq", 1'b0);
    wctl(32'h80);
    rctl(32'h80);
    $display("done: timer");
  endtask
  task automatic t_ext;
    wr(`CIC_OFS_ISTAT, 32'hFF);
    wr(`CIC_OFS_IMASK, 32'h02);
    u_src.ext_edge;
    rctl(32'h82);
    lvl("out", 1'b1);
    wctl(32'h92);
    lvl("irq", 1'b1);
    wctl(32'h82);
    lvl("irq", 1'b0);
    wr(`CIC_OFS_ISTAT, 32'h02);
    lvl("out", 1'b0);
    $display("done: ext");
  endtask
  task automatic t_port;
    wr(`CIC_OFS_IOC, 32'h3F);
    rchk("port", `CIC_OFS_PORT, 32'h0);
    wctl(32'h08);
    u_src.pins(6'h04, 1'b1, 8'h00);
    lvl("wake", 1'b1);
    rctl(32'h09);
    wctl(32'h08);
    rctl(32'h09);
    rchk("port", `CIC_OFS_PORT, 32'h04);
    wctl(32'h08);
    rctl(32'h08);
    wr(`CIC_OFS_IOC, 32'h3B);
    u_src.pins(6'h00, 1'b0, 8'h00);
    rctl(32'h08);
    $display("done: port");
  endtask
  task automatic t_periph;
    u_src.pins(6'h00, 1'b0, 8'h01);
    rchk("pflag", `CIC_OFS_PFLAG, 32'h01);
    wr(`CIC_OFS_PEN, 32'h01);
    wctl(32'h40);
    lvl("irq", 1'b0);
    wctl(32'hC0);
    lvl("irq", 1'b1);
    wctl(32'h80);
    lvl("irq", 1'b0);
    $display("done: periph");
  endtask
  // A pin pulse while the enable is low must leave no trace once it returns
  task automatic t_hold;
    @(posedge mclk);
    ce <= 1'b0;
    u_src.ext_edge;
    @(posedge mclk);
    ce <= 1'b1;
    rctl(32'h80);
    $display("done: hold");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset for ten edges, then the scenarios; a watchdog cuts a hang short
  initial begin
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_timer;
    t_ext;
    t_port;
    t_periph;
    t_hold;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    $display("[ERR] watchdog expired");
    failCount++;
    final_report;
  end
endmodule
